// *** nao_alu.sv ***
// Nibble operation unit: arithmetic and logic between the work nibble and a
// memory operand, or a working register and an immediate, with carry flag and index pointer.
// Assumes the sequencer presents an instruction with valid for one cycle and
// returns the operand (read at mem_addr_out) in the same cycle, combinationally.
//
// Operation
// RULE1: memory subtract gives operand plus inverted work nibble plus one.
// RULE2: flag-affecting arithmetic updates carry_flag from the operation's carry.
// RULE3: starred memory forms store the result into work nibble and memory.
// RULE4: hash forms increment the index pointer after the operation.
// RULE5: indexed forms take the operand address from the index pointer.
// RULE6: add-no-carry forms add but leave carry_flag untouched.
// RULE7: AND loads work nibble with operand AND work nibble.
// RULE8: XOR loads work nibble with operand XOR work nibble.
// RULE9: OR loads work nibble with operand OR work nibble.
// RULE10: immediate forms take a four-bit immediate, zero through fifteen.
// RULE11: add-immediate-carry sums register, immediate and carry, updating carry.
// RULE12: subtract-immediate-borrow adds register, inverted immediate and carry.
// RULE13: add-immediate sums register and immediate, updating carry.
// RULE14: minus-immediate adds register, inverted immediate and one, updating carry.
// RULE15: mask, xor and merge immediates apply AND, XOR, OR with register.
// RULE16: starred immediate forms also write the working register back.
// RULE17: operands are four bits; carry is bit-three carry out, set means no borrow.
`timescale 1ns/1ns
module nao_alu
   import nao_pkg::*;
#(
   parameter int NIB_W  = 4,
   parameter int ADDR_W = 9
) (
   // Clock and reset.
   input  wire logic                  clock_in,
   input  wire logic                  rst_b_in,
   // Instruction from the sequencer.
   input  wire logic                  instr_valid_in,
   input  wire nao_pkg::nao_instr_t   instr_in,
   // Operand path.
   input  wire logic [NIB_W-1:0]      mem_rdata_in,
   input  wire logic [NIB_W-1:0]      reg_rdata_in,
   output logic      [ADDR_W-1:0]     mem_addr_out,
   // Index pointer load from the sequencer.
   input  wire logic                  index_load_in,
   input  wire logic [ADDR_W-1:0]     index_value_in,
   // Results.
   output nao_pkg::nao_wr_t           wr_out,
   output logic      [NIB_W-1:0]      work_nibble_out,
   output logic                       carry_flag_out,
   output logic      [ADDR_W-1:0]     index_pointer_out,
   output logic                       done_out
);
   import nao_pkg::*;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (NIB_W != NAO_NIB_W) begin : g_bad_width
      $error("nao_alu supports a four-bit nibble only");
   end
   if (ADDR_W != NAO_ADDR_W) begin : g_bad_addr
      $error("nao_alu address width must match the package");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [3:0] work_nibble_r;
   logic [3:0] work_nibble_nxt;
   logic       carry_flag_r;
   logic       carry_flag_nxt;
   logic [8:0] index_pointer_r;
   logic [8:0] index_pointer_nxt;
   nao_wr_t    wr_r;
   nao_wr_t    wr_nxt;
   logic       done_r;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   nao_op_t    op;
   logic       is_imm;
   logic       is_sub_mem;
   logic       is_add_imm;
   logic       uses_carry_in;
   logic       invert_b;
   logic       flag_update;
   logic       is_logic;

   // Immediate forms are every code from the carry-add immediate onward.
   assign op          = instr_in.op;
   assign is_imm      = (op >= NAO_OP_ADDIC);
   assign is_sub_mem  = (op == NAO_OP_SUB);
   assign is_add_imm  = (op == NAO_OP_ADD_IMM);
   assign uses_carry_in = (op == NAO_OP_ADDIC) || (op == NAO_OP_SUBIB);
   assign invert_b    = (op == NAO_OP_SUBIB) || (op == NAO_OP_MINUS_IMM);
   assign is_logic    = (op == NAO_OP_AND) || (op == NAO_OP_XOR) || (op == NAO_OP_OR)
                     || (op == NAO_OP_MASKI) || (op == NAO_OP_XORI) || (op == NAO_OP_MERGEI);
   // Add-no-carry forms and logic ops keep the flag. [RULE6] [RULE2]
   assign flag_update = !is_logic && (op != NAO_OP_ADDNC) && (op != NAO_OP_ADDINC);

   // -----------------------------------------------------------------
   // Operand selection
   // -----------------------------------------------------------------
   logic [3:0] opa;
   logic [3:0] opb;
   logic       cin;
   logic [3:0] sum;
   logic       cout;
   logic [3:0] result;
   logic [8:0] operand_addr;

   // Indexed forms address memory through the pointer. [RULE5]
   assign operand_addr = instr_in.indexed ? index_pointer_r : instr_in.direct_addr;
   assign mem_addr_out = operand_addr;

   // Memory subtract: operand + ~work + 1. [RULE1]
   // Immediate forms operate on the working register and the immediate nibble. [RULE10]
   assign opa = is_imm ? reg_rdata_in : mem_rdata_in;
   assign opb = is_imm ? (invert_b ? ~instr_in.imm : instr_in.imm)
                       : (is_sub_mem ? ~work_nibble_r : work_nibble_r);
   // Carry in: flag for the carry forms, one for the subtracts. [RULE11] [RULE12] [RULE14]
   assign cin = uses_carry_in ? carry_flag_r
              : (is_sub_mem || (op == NAO_OP_MINUS_IMM));

   // Shared four-bit adder; its carry out is the flag source. [RULE17]
   nao_nibble_adder #(
      .W         (NAO_NIB_W)
   ) u_adder (
      .a_in      (opa),
      .b_in      (opb),
      .c_in      (cin),
      .sum_out   (sum),
      .carry_out (cout)
   );

   // Result multiplexer for the logic and arithmetic groups.
   always_comb begin
      unique case (op)
         NAO_OP_AND:    result = mem_rdata_in & work_nibble_r;     // [RULE7]
         NAO_OP_XOR:    result = mem_rdata_in ^ work_nibble_r;     // [RULE8]
         NAO_OP_OR:     result = mem_rdata_in | work_nibble_r;     // [RULE9]
         NAO_OP_MASKI:  result = reg_rdata_in & instr_in.imm;      // [RULE15]
         NAO_OP_XORI:   result = reg_rdata_in ^ instr_in.imm;      // [RULE15]
         NAO_OP_MERGEI: result = reg_rdata_in | instr_in.imm;      // [RULE15]
         default:       result = sum;                              // [RULE13]
      endcase
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Each taken instruction loads the work nibble with the result; write-backs follow the star.
   always_comb begin
      work_nibble_nxt   = work_nibble_r;
      carry_flag_nxt    = carry_flag_r;
      index_pointer_nxt = index_pointer_r;
      wr_nxt            = '0;
      if (instr_valid_in) begin
         work_nibble_nxt = result;
         if (flag_update) begin
            carry_flag_nxt = cout;                                  // [RULE2]
         end
         if (instr_in.write_back) begin
            wr_nxt.mem_we = !is_imm;                                // [RULE3]
            wr_nxt.reg_we = is_imm;                                 // [RULE16]
            wr_nxt.addr   = is_imm ? 9'h000 : operand_addr;
            wr_nxt.data   = result;
         end
         // Pointer moves only after the operand address has been used. [RULE4]
         if (!is_imm && instr_in.indexed && instr_in.post_inc) begin
            index_pointer_nxt = index_pointer_r + 9'h001;
         end
      end else if (index_load_in) begin
         index_pointer_nxt = index_value_in;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // A sequencer load is ignored in an instruction cycle, which avoids two
   // writers to the pointer in one edge.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         work_nibble_r   <= NAO_WORK_RST;
         carry_flag_r    <= NAO_CARRY_RST;
         index_pointer_r <= NAO_INDEX_RST;
         wr_r            <= '0;
         done_r          <= 1'b0;
      end else begin
         work_nibble_r   <= work_nibble_nxt;
         carry_flag_r    <= carry_flag_nxt;
         index_pointer_r <= index_pointer_nxt;
         wr_r            <= wr_nxt;
         done_r          <= instr_valid_in;
      end
   end

   // The result outputs come straight from the registers.
   assign wr_out            = wr_r;
   assign work_nibble_out   = work_nibble_r;
   assign carry_flag_out    = carry_flag_r;
   assign index_pointer_out = index_pointer_r;
   assign done_out          = done_r;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_mem_sub;
      instr_valid_in && op == NAO_OP_SUB;
   endsequence

   a_sub_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE1]
      s_mem_sub |=> work_nibble_r == $past(mem_rdata_in) - $past(work_nibble_r))
      else $error("memory subtract result wrong");

   a_flag_update: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE2]
      instr_valid_in && flag_update |=> carry_flag_r == $past(cout))
      else $error("carry flag not updated");

   a_mem_wback: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE3]
      instr_valid_in && instr_in.write_back && !is_imm
      |=> wr_r.mem_we && wr_r.data == work_nibble_r && wr_r.addr == $past(operand_addr))
      else $error("memory write-back missing");

   a_post_inc: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE4]
      instr_valid_in && !is_imm && instr_in.indexed && instr_in.post_inc
      |=> index_pointer_r == $past(index_pointer_r) + 9'h001)
      else $error("index pointer not advanced");

   a_index_addr: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE5]
      instr_valid_in && instr_in.indexed |-> mem_addr_out == index_pointer_r)
      else $error("indexed address not from pointer");

   a_keep_flag: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE6]
      instr_valid_in && (op == NAO_OP_ADDNC || op == NAO_OP_ADDINC) |=> $stable(carry_flag_r))
      else $error("add-no-carry changed the flag");

   a_and_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE7]
      instr_valid_in && op == NAO_OP_AND
      |=> work_nibble_r == ($past(mem_rdata_in) & $past(work_nibble_r)))
      else $error("AND result wrong");

   a_addic_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE11]
      instr_valid_in && op == NAO_OP_ADDIC
      |=> {carry_flag_r, work_nibble_r} == {1'b0, $past(reg_rdata_in)}
          + {1'b0, $past(instr_in.imm)} + {4'h0, $past(carry_flag_r)})
      else $error("add immediate with carry wrong");

   a_reg_wback: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE16]
      instr_valid_in && instr_in.write_back && is_imm
      |=> wr_r.reg_we && !wr_r.mem_we && wr_r.data == work_nibble_r)
      else $error("working register write-back missing");

   // The remaining memory logic forms follow the same one-cycle pattern.
   a_xor_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE8]
      instr_valid_in && op == NAO_OP_XOR
      |=> work_nibble_r == ($past(mem_rdata_in) ^ $past(work_nibble_r)))
      else $error("XOR result wrong");

   a_or_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE9]
      instr_valid_in && op == NAO_OP_OR
      |=> work_nibble_r == ($past(mem_rdata_in) | $past(work_nibble_r)))
      else $error("OR result wrong");

   // Logic operations never disturb the flag, so a pending borrow survives a mask.
   a_logic_flag: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE2]
      instr_valid_in && is_logic |=> $stable(carry_flag_r))
      else $error("logic operation changed the flag");

   // Immediate arithmetic: the flag and the nibble form one five-bit sum.
   sequence s_imm_taken;
      instr_valid_in && is_imm;
   endsequence

   a_subib_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE12]
      instr_valid_in && op == NAO_OP_SUBIB
      |=> {carry_flag_r, work_nibble_r} == {1'b0, $past(reg_rdata_in)}
          + {1'b0, ~$past(instr_in.imm)} + {4'h0, $past(carry_flag_r)})
      else $error("subtract immediate with borrow wrong");

   a_add_imm_result: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE13]
      instr_valid_in && is_add_imm
      |=> {carry_flag_r, work_nibble_r} == {1'b0, $past(reg_rdata_in)}
          + {1'b0, $past(instr_in.imm)})
      else $error("add immediate wrong");

   a_minus_imm: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE14]
      instr_valid_in && op == NAO_OP_MINUS_IMM
      |=> {carry_flag_r, work_nibble_r} == {1'b0, $past(reg_rdata_in)}
          + {1'b0, ~$past(instr_in.imm)} + 5'h01)
      else $error("minus immediate wrong");

   a_mask_imm: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE15]
      instr_valid_in && op == NAO_OP_MASKI
      |=> work_nibble_r == ($past(reg_rdata_in) & $past(instr_in.imm)))
      else $error("mask immediate wrong");

   a_xor_imm: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE15]
      instr_valid_in && op == NAO_OP_XORI
      |=> work_nibble_r == ($past(reg_rdata_in) ^ $past(instr_in.imm)))
      else $error("xor immediate wrong");

   a_merge_imm: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE15]
      instr_valid_in && op == NAO_OP_MERGEI
      |=> work_nibble_r == ($past(reg_rdata_in) | $past(instr_in.imm)))
      else $error("merge immediate wrong");

   // Immediate forms never store to data memory nor move the pointer.
   a_imm_no_mem: assert property (@(posedge clock_in) disable iff (!rst_b_in) // [RULE16]
      s_imm_taken |=> !wr_r.mem_we && index_pointer_r == $past(index_pointer_r))
      else $error("immediate form touched memory or pointer");

endmodule

// *** nao_nibble_adder.sv ***
// Four-bit adder with carry in and carry out.
// Assumes operands are already complemented by the caller where needed.
`timescale 1ns/1ns
module nao_nibble_adder #(
   parameter int W = 4
) (
   // Operands.
   input  wire logic [W-1:0] a_in,
   input  wire logic [W-1:0] b_in,
   input  wire logic         c_in,
   // Result.
   output logic      [W-1:0] sum_out,
   output logic              carry_out
);

   // -----------------------------------------------------------------
   // Sum
   // -----------------------------------------------------------------
   logic [W:0] wide;

   // The carry is the bit above the top of the nibble.
   assign wide      = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, c_in};
   assign sum_out   = wide[W-1:0];
   assign carry_out = wide[W];

endmodule

// *** nao_pkg.sv ***
// Package for the nibble operation unit: operation codes, widths, reset values.
// Assumes a single 100 MHz clock and the core sequencer as the only user.
package nao_pkg;

   // -----------------------------------------------------------------
   // Widths and reset values
   // -----------------------------------------------------------------
   localparam int          NAO_NIB_W      = 4;
   localparam int          NAO_ADDR_W     = 9;
   localparam logic [3:0]  NAO_WORK_RST   = 4'h0;
   localparam logic        NAO_CARRY_RST  = 1'b0;
   localparam logic [8:0]  NAO_INDEX_RST  = 9'h000;
   localparam logic [3:0]  NAO_IMM_MAX    = 4'hf;

   // Operation selected by the sequencer.
   typedef enum logic [3:0] {
      NAO_OP_SUB,
      NAO_OP_ADDNC,
      NAO_OP_AND,
      NAO_OP_XOR,
      NAO_OP_OR,
      NAO_OP_ADDIC,
      NAO_OP_SUBIB,
      NAO_OP_ADD_IMM,
      NAO_OP_MINUS_IMM,
      NAO_OP_ADDINC,
      NAO_OP_MASKI,
      NAO_OP_XORI,
      NAO_OP_MERGEI
   } nao_op_t;

   // One instruction as issued by the sequencer.
   typedef struct packed {
      nao_op_t              op;
      logic                 indexed;     // Operand address from index pointer.
      logic                 post_inc;    // Advance the index pointer afterwards.
      logic                 write_back;  // Starred form: also store the result.
      logic [8:0]           direct_addr; // Address field for direct forms.
      logic [3:0]           imm;         // Immediate nibble.
   } nao_instr_t;

   // Write request to data memory or the working register.
   typedef struct packed {
      logic                 mem_we;
      logic                 reg_we;
      logic [8:0]           addr;
      logic [3:0]           data;
   } nao_wr_t;

endpackage

// *** testbench.sv ***
// Self-checking bench for the nibble operation unit, one task per scenario.
// Assumes the unit answers exactly one cycle after each taken instruction.
`timescale 1ns/1ns
module testbench;
   import nao_pkg::*;
   // -----------------------------------------------------------------
   // Stimulus, observed outputs and expected state
   // -----------------------------------------------------------------
   logic       clock_in       = 1'b0;
   logic       rst_b_in       = 1'b0;
   logic       instr_valid_in = 1'b0;
   nao_instr_t instr_in       = '0;
   logic [3:0] mem_rdata_in   = 4'h0;
   logic [3:0] reg_rdata_in   = 4'h0;
   logic       index_load_in  = 1'b0;
   logic [8:0] index_value_in = 9'h000;
   logic [8:0] mem_addr_out;
   logic [8:0] index_pointer_out;
   nao_wr_t    wr_out;
   logic [3:0] work_nibble_out;
   logic       carry_flag_out;
   logic       done_out;
   logic [3:0] e_work = 4'h0;
   logic       e_cf   = 1'b0;
   logic [8:0] e_ptr  = 9'h000;
   int         fails       = 0;
   int         checks_done = 0;

   nao_alu u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .mem_rdata_in(mem_rdata_in), .reg_rdata_in(reg_rdata_in),
      .mem_addr_out(mem_addr_out), .index_load_in(index_load_in),
      .index_value_in(index_value_in), .wr_out(wr_out), .work_nibble_out(work_nibble_out),
      .carry_flag_out(carry_flag_out), .index_pointer_out(index_pointer_out),
      .done_out(done_out));

   // Free-running 100 MHz clock.
   initial forever #5 clock_in = ~clock_in;

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // Case equality, so an unknown output never passes for a match.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s ended: checks %0d mismatches %0d", name, checks_done, fails);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One instruction: drive for one cycle, predict, then judge the answer.
   // A pointer load held during the instruction must be ignored.
   task automatic do_op(input nao_op_t o, input logic ix, input logic pi, input logic wb,
                        input logic [8:0] ad, input logic [3:0] im, input logic [3:0] md,
                        input logic [3:0] rd, input logic ld);
      logic       memop;
      logic [3:0] nw;
      logic [3:0] ni;
      logic [4:0] s;
      logic [8:0] ea;
      memop = (o <= NAO_OP_OR);
      nw    = ~e_work;
      ni    = ~im;
      ea    = ix ? e_ptr : ad;
      case (o)
         NAO_OP_SUB:    s = md + nw + 5'h01;
         NAO_OP_ADDNC:  s = md + e_work;
         NAO_OP_AND:    s = {1'b0, md & e_work};
         NAO_OP_XOR:    s = {1'b0, md ^ e_work};
         NAO_OP_OR:     s = {1'b0, md | e_work};
         NAO_OP_ADDIC:  s = rd + im + e_cf;
         NAO_OP_SUBIB:  s = rd + ni + e_cf;
         NAO_OP_ADD_IMM:   s = rd + im;
         NAO_OP_MINUS_IMM: s = rd + ni + 5'h01;
         NAO_OP_ADDINC: s = rd + im;
         NAO_OP_MASKI:  s = {1'b0, rd & im};
         NAO_OP_XORI:   s = {1'b0, rd ^ im};
         default:       s = {1'b0, rd | im};
      endcase
      @(posedge clock_in);
      instr_valid_in <= 1'b1;
      instr_in       <= {o, ix, pi, wb, ad, im};
      mem_rdata_in   <= md;
      reg_rdata_in   <= rd;
      index_load_in  <= ld;
      index_value_in <= 9'h0aa;
      #1;
      chk(16'(mem_addr_out), 16'(ea));
      chk(16'({done_out, wr_out.mem_we, wr_out.reg_we}), 16'h0000);
      @(posedge clock_in);
      instr_valid_in <= 1'b0;
      index_load_in  <= 1'b0;
      #1;
      e_work = s[3:0];
      if (o inside {NAO_OP_SUB, NAO_OP_ADDIC, NAO_OP_SUBIB, NAO_OP_ADD_IMM,
                    NAO_OP_MINUS_IMM}) begin
         e_cf = s[4];
      end
      if (memop && ix && pi) begin
         e_ptr = e_ptr + 9'h001;
      end
      chk(16'(work_nibble_out), 16'(e_work));
      chk(16'(carry_flag_out), 16'(e_cf));
      chk(16'(index_pointer_out), 16'(e_ptr));
      chk(16'({done_out, wr_out.mem_we, wr_out.reg_we}),
          16'({1'b1, memop & wb, !memop & wb}));
      if (wb) begin
         chk(16'({wr_out.addr, wr_out.data}),
             16'({memop ? ea : 9'h000, e_work}));
      end
   endtask

   task automatic load_ptr(input logic [8:0] v);
      @(posedge clock_in);
      index_load_in  <= 1'b1;
      index_value_in <= v;
      @(posedge clock_in);
      index_load_in  <= 1'b0;
      #1;
      e_ptr = v;
      chk(16'(index_pointer_out), 16'(v));
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_sub;
      load_ptr(9'h010);
      do_op(NAO_OP_ADDINC, 1'b0, 1'b0, 1'b0, 9'h000, 4'h0, 4'h0, 4'h5, 1'b0);
      do_op(NAO_OP_SUB, 1'b0, 1'b1, 1'b0, 9'h123, 4'h0, 4'h3, 4'h0, 1'b0);
      do_op(NAO_OP_SUB, 1'b1, 1'b1, 1'b1, 9'h123, 4'h0, 4'hf, 4'h0, 1'b1);
      do_op(NAO_OP_SUB, 1'b1, 1'b0, 1'b1, 9'h000, 4'h0, 4'h1, 4'h0, 1'b0);
      do_op(NAO_OP_SUB, 1'b0, 1'b0, 1'b1, 9'h1fe, 4'h0, 4'h0, 4'h0, 1'b0);
      end_test("sub");
   endtask

   task automatic t_addnc;
      do_op(NAO_OP_ADD_IMM, 1'b0, 1'b0, 1'b0, 9'h000, 4'h1, 4'h0, 4'hf, 1'b0);
      for (int f = 0; f < 4; f++) begin
         do_op(NAO_OP_ADDNC, f[0], 1'b1, f[1], 9'h055, 4'h0, 4'hf, 4'h0, 1'b0);
      end
      do_op(NAO_OP_ADDINC, 1'b0, 1'b0, 1'b1, 9'h000, 4'hf, 4'h0, 4'h3, 1'b0);
      end_test("add_no_carry");
   endtask

   task automatic t_logic;
      for (int o = 2; o < 5; o++) begin
         for (int f = 0; f < 4; f++) begin
            do_op(nao_op_t'(o), f[0], 1'b1, f[1], 9'h0c3, 4'h0, 4'(4'h6 + f), 4'h0,
                  1'b0);
         end
      end
      end_test("logic");
   endtask

   task automatic t_imm;
      for (int o = 5; o < 13; o++) begin
         for (int k = 0; k < 3; k++) begin
            do_op(nao_op_t'(o), 1'b1, 1'b1, k[0], 9'h1ff,
                  k == 1 ? NAO_IMM_MAX : 4'(k * 7), 4'ha, 4'(4'h9 + o + k),
                  1'b0);
         end
      end
      end_test("immediate");
   endtask

   task automatic t_wrap_reset;
      load_ptr(9'h1ff);
      do_op(NAO_OP_XOR, 1'b1, 1'b1, 1'b1, 9'h000, 4'h0, 4'h9, 4'h0, 1'b0);
      @(posedge clock_in);
      rst_b_in <= 1'b0;
      #1;
      chk(16'(wr_out), 16'h0000);
      chk(16'({work_nibble_out, carry_flag_out, index_pointer_out, done_out}), 16'h0000);
      @(posedge clock_in);
      rst_b_in <= 1'b1;
      e_work = NAO_WORK_RST;
      e_cf   = NAO_CARRY_RST;
      e_ptr  = NAO_INDEX_RST;
      do_op(NAO_OP_ADDIC, 1'b0, 1'b0, 1'b0, 9'h000, 4'h4, 4'h0, 4'h2, 1'b0);
      end_test("wrap_and_reset");
   endtask

   // -----------------------------------------------------------------
   // Main sequence and hang guard
   // -----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clock_in);
      rst_b_in <= 1'b1;
      #1;
      chk(16'({work_nibble_out, carry_flag_out, index_pointer_out, done_out}), 16'h0000);
      t_sub();
      t_addnc();
      t_logic();
      t_imm();
      t_wrap_reset();
      give_verdict();
   end

   // The whole run is far shorter than this bound; reaching it means a hang.
   initial begin
      repeat (20000) @(posedge clock_in);
      fails++;
      give_verdict();
   end
endmodule
